// [design/cpu_level_register_file.sv]
// Purpose: Per-level register file, operand selection, status word and micro sequencer.
// Assumes: All inputs are synchronous to CLK_IN; the ALU drives RF_WDATA_IN from WORK_SEL_OUT during a save.
// Notes: Entry point table is loaded over APB before the first instruction.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "cpu_level_regs.svh"
module cpu_level_register_file (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Instruction and sequencer control
   input wire logic [15:0] INSTR_IN,
   input wire cpu_level_pkg::seq_src_type SEQ_SRC_IN,
   input wire cpu_level_pkg::stack_op_type STACK_OP_IN,
   input wire logic [11:0] BRANCH_IN,
   input wire logic INSTR_DONE_IN,
   input wire logic IRQ_PEND_IN,
   output logic [11:0] UADDR_OUT,
   output logic [10:0] OPCODE_OUT,
   // Operand selection and register file access
   input wire cpu_level_pkg::a_src_type A_SRC_IN,
   input wire cpu_level_pkg::b_src_type B_SRC_IN,
   input wire logic [3:0] MICRO_A_IN,
   input wire logic [3:0] MICRO_B_IN,
   input wire logic LOOP_LOAD_IN,
   input wire logic LOOP_FROM_OPL_IN,
   input wire logic LOOP_DEC_IN,
   input wire logic RF_RD_IN,
   input wire logic RF_WR_IN,
   input wire logic MASK_EN_IN,
   input wire logic [15:0] RF_WDATA_IN,
   output logic [15:0] BUS_OUT,
   output logic BUS_VALID_OUT,
   // Level change
   input wire logic LEVEL_CHANGE_IN,
   input wire logic [3:0] NEW_LEVEL_IN,
   output logic SAVE_ACTIVE_OUT,
   output logic [3:0] WORK_SEL_OUT,
   output logic WORK_LOAD_OUT,
   output logic [3:0] LOAD_SEL_OUT,
   output logic [3:0] CUR_LEVEL_OUT,
   // Status flags
   input wire logic FLAGS_VALID_IN,
   input wire logic CARRY_IN,
   input wire logic OVF_IN,
   input wire logic ERR_EVT_IN,
   input wire logic SPILL_VALID_IN,
   input wire logic SPILL_IN,
   input wire logic BIT_WR_IN,
   input wire logic BIT_IN,
   input wire logic STATUS_LOAD_IN,
   output logic [7:0] STATUS_LO_OUT,
   output logic ERROR_IRQ_OUT,
   output logic ALT_TABLE_OUT
);
   import cpu_level_pkg::*;

   logic [15:0] regfile [0:255];
   logic [11:0] entry_rom [0:1023];
   logic [11:0] uaddr_q;
   logic [11:0] uaddr_d;
   logic [11:0] stack_q [0:3];
   logic [2:0] sp_q;
   logic [10:0] opl_q;
   logic [3:0] loop_q;
   logic [3:0] level_q;
   logic [3:0] new_level_q;
   logic [7:0] status_lo_q;
   logic [7:0] status_lo_d;
   logic [2:0] upper_q;
   logic [15:0] bus_q;
   logic bus_valid_q;
   logic work_load_q;
   logic [3:0] load_sel_q;
   lvl_state_type state_q;
   logic [3:0] a_opnd;
   logic [3:0] b_opnd;
   logic [7:0] rf_idx;
   logic idle;
   logic map_jump;
   logic [11:0] map_word;
   logic [15:0] rd_word;
   logic [10:0] instr_lo;
   logic [7:0] upper_byte;
   logic [31:0] rdata_d;
   logic addr_ok;
   logic apb_wr;

   assign idle = state_q == LV_IDLE;
   assign map_jump = SEQ_SRC_IN == SEQ_MAP && !INSTR_DONE_IN;
   assign map_word = entry_rom[INSTR_IN[`OPC_MSB:`OPC_LSB]];
   assign instr_lo = INSTR_IN[`OPL_MSB:0];
   assign upper_byte = {level_q, `MTYPE_VALUE, upper_q};
   assign rd_word = regfile[rf_idx];

   always_comb begin
      unique case (A_SRC_IN)
         A_MICRO: a_opnd = MICRO_A_IN;
         A_SRCREG: a_opnd = {1'b0, opl_q[5:3]};
         A_BITLVL: a_opnd = opl_q[6:3];
         A_LEVEL: a_opnd = level_q;
         A_LOOP: a_opnd = loop_q;
         default: a_opnd = MICRO_A_IN;
      endcase
      unique case (B_SRC_IN)
         B_MICRO: b_opnd = MICRO_B_IN;
         B_SRCREG: b_opnd = {1'b0, opl_q[5:3]};
         B_DSTREG: b_opnd = {1'b0, opl_q[2:0]};
         B_LOOP: b_opnd = loop_q;
      endcase
      unique case (state_q)
         LV_SAVE: rf_idx = {level_q, loop_q};
         LV_LOAD: rf_idx = {new_level_q, loop_q};
         LV_IDLE: rf_idx = {a_opnd, b_opnd};
         default: rf_idx = {a_opnd, b_opnd};
      endcase
   end

   // Opcode latch is loaded on every map request that INSTR_DONE_IN does not override, also when a pending interrupt diverts it from the entry table.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         opl_q <= 11'h000;
      end else if (map_jump) begin
         opl_q <= instr_lo;
      end
   end

   always_comb begin
      if (INSTR_DONE_IN) begin
         uaddr_d = `FETCH_UADDR;
      end else begin
         unique case (SEQ_SRC_IN)
            SEQ_NEXT: uaddr_d = uaddr_q + 12'h001;
            SEQ_JUMP: uaddr_d = BRANCH_IN;
            SEQ_RETURN: uaddr_d = (sp_q != 3'h0) ? stack_q[sp_q[1:0] - 2'h1] : uaddr_q;
            SEQ_REPEAT: uaddr_d = uaddr_q;
            SEQ_MAP: uaddr_d = IRQ_PEND_IN ? `IRQ_UADDR : map_word;
            default: uaddr_d = uaddr_q;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         uaddr_q <= `FETCH_UADDR;
      end else begin
         uaddr_q <= uaddr_d;
      end
   end

   // A push on a full stack is dropped, so a runaway nest loses the newest link, not the oldest.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sp_q <= 3'h0;
      end else if (STACK_OP_IN == STK_PUSH && sp_q != `STACK_DEPTH) begin
         sp_q <= sp_q + 3'h1;
      end else if (STACK_OP_IN == STK_POP && sp_q != 3'h0) begin
         sp_q <= sp_q - 3'h1;
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_stack
      always_ff @(posedge CLK_IN) begin
         if (RST_IN) begin
            stack_q[i] <= `FETCH_UADDR;
         end else if ((STACK_OP_IN == STK_PUSH && sp_q == 3'(i)) ||
                      (STACK_OP_IN == STK_LOAD && sp_q == 3'(i + 1))) begin
            stack_q[i] <= uaddr_q + 12'h001;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state_q <= LV_IDLE;
         loop_q <= 4'h0;
         level_q <= `LEVEL_RESET;
         new_level_q <= `LEVEL_RESET;
      end else begin
         unique case (state_q)
            LV_IDLE: begin
               if (LEVEL_CHANGE_IN) begin
                  state_q <= LV_SAVE;
                  new_level_q <= NEW_LEVEL_IN;
                  loop_q <= 4'h0;
               end else if (LOOP_LOAD_IN) begin
                  loop_q <= LOOP_FROM_OPL_IN ? opl_q[3:0] : MICRO_B_IN;
               end else if (LOOP_DEC_IN) begin
                  loop_q <= loop_q - 4'h1;
               end
            end
            LV_SAVE: begin
               loop_q <= (loop_q == `BLOCK_LAST) ? 4'h0 : loop_q + 4'h1;
               if (loop_q == `BLOCK_LAST) begin
                  state_q <= LV_LOAD;
               end
            end
            LV_LOAD: begin
               loop_q <= (loop_q == `BLOCK_LAST) ? 4'h0 : loop_q + 4'h1;
               if (loop_q == `BLOCK_LAST) begin
                  state_q <= LV_IDLE;
                  level_q <= new_level_q;
               end
            end
         endcase
      end
   end

   // Single write port: write wins, a read in the same cycle is dropped.
   always_ff @(posedge CLK_IN) begin
      if (state_q == LV_SAVE) begin
         regfile[rf_idx] <= (loop_q == `STATUS_REG) ? {8'h00, status_lo_q} : RF_WDATA_IN;
      end else if (idle && RF_WR_IN) begin
         regfile[rf_idx] <= RF_WDATA_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         bus_q <= 16'h0000;
         bus_valid_q <= 1'b0;
         work_load_q <= 1'b0;
         load_sel_q <= 4'h0;
      end else begin
         bus_valid_q <= 1'b0;
         work_load_q <= 1'b0;
         if (state_q == LV_LOAD) begin
            bus_q <= rd_word;
            work_load_q <= 1'b1;
            load_sel_q <= loop_q;
         end else if (idle && !RF_WR_IN && RF_RD_IN) begin
            bus_q <= rd_word;
            bus_valid_q <= 1'b1;
         end else if (idle && !RF_WR_IN && MASK_EN_IN) begin
            bus_q <= 16'h0001 << a_opnd;
            bus_valid_q <= 1'b1;
         end
      end
   end

   // Hardware sets are applied after the load so an event never gets lost to a clear.
   always_comb begin
      status_lo_d = status_lo_q;
      if (state_q == LV_LOAD && loop_q == `STATUS_REG) begin
         status_lo_d = rd_word[7:0];
      end else if (STATUS_LOAD_IN) begin
         status_lo_d = RF_WDATA_IN[7:0];
      end
      if (FLAGS_VALID_IN) begin
         status_lo_d[`ST_CARRY] = CARRY_IN;
         status_lo_d[`ST_OVF_LIVE] = OVF_IN;
         if (OVF_IN) begin
            status_lo_d[`ST_OVF_STICKY] = 1'b1;
         end
      end
      if (ERR_EVT_IN) begin
         status_lo_d[`ST_ERR] = 1'b1;
      end
      if (SPILL_VALID_IN) begin
         status_lo_d[`ST_SPILL] = SPILL_IN;
      end
      if (BIT_WR_IN) begin
         status_lo_d[`ST_BITACC] = BIT_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         status_lo_q <= `STATUS_LO_RESET;
      end else begin
         status_lo_q <= status_lo_d;
      end
   end

   assign addr_ok = PADDR_IN == `OFF_STATUS || PADDR_IN == `OFF_LEVEL || PADDR_IN == `OFF_MAPWR ||
                    PADDR_IN == `OFF_SEQ;
   assign apb_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (PADDR_IN == `OFF_STATUS) begin
         rdata_d = {16'h0000, upper_byte, status_lo_q};
      end else if (PADDR_IN == `OFF_LEVEL) begin
         rdata_d = {27'h0000000, !idle, level_q};
      end else if (PADDR_IN == `OFF_SEQ) begin
         rdata_d = {17'h00000, sp_q, uaddr_q};
      end
   end

   // Answer is registered at setup, so every transfer completes with zero wait states.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0000_0000;
      end else begin
         PREADY_OUT <= PSEL_IN && !PENABLE_IN;
         PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
         PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? rdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         upper_q <= `UPPER_RESET;
      end else if (apb_wr && PADDR_IN == `OFF_STATUS) begin
         upper_q <= PWDATA_IN[10:8];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (apb_wr && PADDR_IN == `OFF_MAPWR) begin
         entry_rom[PWDATA_IN[`MAPWR_ADDR_MSB:`MAPWR_ADDR_LSB]] <= PWDATA_IN[11:0];
      end
   end

   assign UADDR_OUT = uaddr_q;
   assign OPCODE_OUT = opl_q;
   assign BUS_OUT = bus_q;
   assign BUS_VALID_OUT = bus_valid_q;
   assign SAVE_ACTIVE_OUT = state_q[1];
   assign WORK_SEL_OUT = loop_q;
   assign WORK_LOAD_OUT = work_load_q;
   assign LOAD_SEL_OUT = load_sel_q;
   assign CUR_LEVEL_OUT = level_q;
   assign STATUS_LO_OUT = status_lo_q;
   assign ERROR_IRQ_OUT = status_lo_q[`ST_ERR];
   assign ALT_TABLE_OUT = status_lo_q[`ST_ALTTAB];

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   property p_map;
      map_jump && !IRQ_PEND_IN |=> uaddr_q == $past(map_word);
   endproperty
   a_map: assert property (p_map) else $error("Entry table jump went wrong.");
   property p_opl;
      map_jump |=> opl_q == $past(instr_lo);
   endproperty
   a_opl: assert property (p_opl) else $error("Opcode latch not loaded.");
   property p_fetch;
      INSTR_DONE_IN |=> uaddr_q == `FETCH_UADDR;
   endproperty
   a_fetch: assert property (p_fetch) else $error("No return to fetch.");
   property p_level;
      idle && LEVEL_CHANGE_IN |=> (state_q == LV_SAVE)[*8] ##1 (state_q == LV_LOAD)[*8] ##1
         (idle && level_q == $past(new_level_q));
   endproperty
   a_level: assert property (p_level) else $error("Level change sequence wrong.");
   property p_read;
      idle && RF_RD_IN && !RF_WR_IN |=> BUS_VALID_OUT && BUS_OUT == $past(rd_word);
   endproperty
   a_read: assert property (p_read) else $error("Register read data wrong.");
   property p_mask;
      idle && MASK_EN_IN && !RF_RD_IN && !RF_WR_IN |=> $onehot(BUS_OUT) && BUS_OUT == 16'h0001 << $past(a_opnd);
   endproperty
   a_mask: assert property (p_mask) else $error("Mask word wrong.");
   property p_asel;
      A_SRC_IN == A_BITLVL |-> a_opnd == opl_q[6:3];
   endproperty
   a_asel: assert property (p_asel) else $error("A operand source wrong.");
   property p_err;
      ERR_EVT_IN ##1 (!STATUS_LOAD_IN && state_q != LV_LOAD) [*2] |-> ERROR_IRQ_OUT;
   endproperty
   a_err: assert property (p_err) else $error("Sticky error lost.");
   property p_carry;
      FLAGS_VALID_IN |=> STATUS_LO_OUT[`ST_CARRY] == $past(CARRY_IN);
   endproperty
   a_carry: assert property (p_carry) else $error("Carry not dynamic.");
   property p_upper;
      STATUS_LOAD_IN && idle && !apb_wr |=> $stable(upper_byte);
   endproperty
   a_upper: assert property (p_upper) else $error("Status load touched upper byte.");
   property p_stack;
      sp_q <= `STACK_DEPTH;
   endproperty
   a_stack: assert property (p_stack) else $error("Stack depth exceeded.");
   c_level: cover property (idle && LEVEL_CHANGE_IN ##17 idle);
   c_irq: cover property (map_jump && IRQ_PEND_IN);
   c_full: cover property (sp_q == `STACK_DEPTH);
endmodule

// [design/cpu_level_regs.svh]
// Purpose: Offsets, field positions, reset values and counts of the level register file.
// Assumes: Included by the register file module and by its bench.
// Notes: Definitions only.
`ifndef CPU_LEVEL_REGS_SVH
`define CPU_LEVEL_REGS_SVH
`define OFF_STATUS 8'h00
`define OFF_LEVEL 8'h04
`define OFF_MAPWR 8'h08
`define OFF_SEQ 8'h0C
`define FETCH_UADDR 12'h000
`define IRQ_UADDR 12'h010
`define OPC_LSB 6
`define OPC_MSB 15
`define OPL_MSB 10
`define MAPWR_ADDR_LSB 16
`define MAPWR_ADDR_MSB 25
`define ST_SPILL 0
`define ST_CARRY 1
`define ST_OVF_STICKY 2
`define ST_OVF_LIVE 3
`define ST_ERR 4
`define ST_BITACC 5
`define ST_ROUND 6
`define ST_ALTTAB 7
`define ST_IRQ_ON 0
`define ST_PAGING 1
`define ST_WIDE 2
`define STATUS_LO_RESET 8'h00
`define UPPER_RESET 3'h0
`define LEVEL_RESET 4'h0
`define MTYPE_VALUE 1'b1
`define STACK_DEPTH 3'h4
`define BLOCK_LAST 4'h7
`define STATUS_REG 4'h0
`endif

// [design/cpu_level_pkg.sv]
// Purpose: Types shared by the level register file and its bench.
// Assumes: Encodings are chosen freely; the microword carries them as given here.
// Notes: Numeric constants live in cpu_level_regs.svh.
package cpu_level_pkg;
   typedef enum logic [2:0] {A_MICRO = 3'h0, A_SRCREG = 3'h1, A_BITLVL = 3'h2, A_LEVEL = 3'h3,
      A_LOOP = 3'h4} a_src_type;
   typedef enum logic [1:0] {B_MICRO = 2'h0, B_SRCREG = 2'h1, B_DSTREG = 2'h2, B_LOOP = 2'h3} b_src_type;
   typedef enum logic [2:0] {SEQ_NEXT = 3'h0, SEQ_JUMP = 3'h1, SEQ_RETURN = 3'h2, SEQ_REPEAT = 3'h3,
      SEQ_MAP = 3'h4} seq_src_type;
   typedef enum logic [1:0] {STK_HOLD = 2'h0, STK_POP = 2'h1, STK_PUSH = 2'h2, STK_LOAD = 2'h3} stack_op_type;
   typedef enum logic [2:0] {LV_IDLE = 3'b001, LV_SAVE = 3'b010, LV_LOAD = 3'b100} lvl_state_type;
endpackage

// [testbench/alu_partner.sv]
// Purpose: Model of the ALU side that holds the working register block of the current level.
// Assumes: The save walk names one working register per cycle and expects its word in that same cycle.
// Notes: The output is only used while a save runs; the bench muxes its own data in otherwise.
`timescale 1ns/100ps
module alu_partner (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Block transfer from the register file
   input wire logic [3:0] sel_in,
   input wire logic load_in,
   input wire logic [3:0] load_sel_in,
   input wire logic [15:0] bus_in,
   // Word handed to the register file
   output logic [15:0] wdata_out
);
   logic [15:0] work_q [0:7];

   // Answers at once, since the save walk gives no wait cycle.
   assign wdata_out = work_q[sel_in[2:0]];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 8; i++) begin
            work_q[i] <= 16'h00A0 + 16'(i);
         end
      end else if (load_in) begin
         work_q[load_sel_in[2:0]] <= bus_in;
      end
   end
endmodule

// [testbench/cpu_level_register_file_test.sv]
// Purpose: Self-checking bench for the level register file.
// Assumes: Status load takes its byte from the register file write data.
// Notes: Register contents are written before they are read back, except entries 0x22 to 0x27, which the level 2 load reads unwritten.
`timescale 1ns/100ps
`include "cpu_level_regs.svh"
module cpu_level_register_file_test;
   import cpu_level_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] instr = 16'h0000, wdata = 16'h0000, rf_wdata, alu_wdata, bus_q;
   seq_src_type seq_src = SEQ_NEXT;
   stack_op_type stack_op = STK_HOLD;
   a_src_type a_src = A_MICRO;
   b_src_type b_src = B_MICRO;
   logic [11:0] uaddr;
   logic [11:0] branch = 12'h000;
   logic [10:0] opcode;
   logic [3:0] ma = 4'h0, mb = 4'h0, new_lvl = 4'h0, work_sel, load_sel, cur_lvl;
   logic done = 1'b0, irq = 1'b0, loop_ld = 1'b0, loop_opl = 1'b0, loop_dec = 1'b0, rf_rd = 1'b0;
   logic rf_wr = 1'b0, mask_en = 1'b0, lvl_chg = 1'b0, flags_v = 1'b0, carry = 1'b0, ovf = 1'b0;
   logic err_evt = 1'b0, spill_v = 1'b0, spill = 1'b0, bit_wr = 1'b0, bit_d = 1'b0, status_ld = 1'b0;
   logic bus_v, save_act, work_ld, err_irq, alt_tab;
   logic [7:0] status_lo;
   int errors = 0;
   int n_tests = 0;

   always #2.5 clk = ~clk;
   assign rf_wdata = save_act ? alu_wdata : wdata;

   cpu_level_register_file dut_u (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .INSTR_IN(instr), .SEQ_SRC_IN(seq_src), .STACK_OP_IN(stack_op),
      .BRANCH_IN(branch), .INSTR_DONE_IN(done), .IRQ_PEND_IN(irq), .UADDR_OUT(uaddr), .OPCODE_OUT(opcode),
      .A_SRC_IN(a_src), .B_SRC_IN(b_src), .MICRO_A_IN(ma), .MICRO_B_IN(mb), .LOOP_LOAD_IN(loop_ld),
      .LOOP_FROM_OPL_IN(loop_opl), .LOOP_DEC_IN(loop_dec), .RF_RD_IN(rf_rd), .RF_WR_IN(rf_wr),
      .MASK_EN_IN(mask_en), .RF_WDATA_IN(rf_wdata), .BUS_OUT(bus_q), .BUS_VALID_OUT(bus_v),
      .LEVEL_CHANGE_IN(lvl_chg), .NEW_LEVEL_IN(new_lvl), .SAVE_ACTIVE_OUT(save_act), .WORK_SEL_OUT(work_sel),
      .WORK_LOAD_OUT(work_ld), .LOAD_SEL_OUT(load_sel), .CUR_LEVEL_OUT(cur_lvl), .FLAGS_VALID_IN(flags_v),
      .CARRY_IN(carry), .OVF_IN(ovf), .ERR_EVT_IN(err_evt), .SPILL_VALID_IN(spill_v), .SPILL_IN(spill),
      .BIT_WR_IN(bit_wr), .BIT_IN(bit_d), .STATUS_LOAD_IN(status_ld), .STATUS_LO_OUT(status_lo),
      .ERROR_IRQ_OUT(err_irq), .ALT_TABLE_OUT(alt_tab));

   alu_partner alu_u (.clk_in(clk), .rst_in(rst), .sel_in(work_sel), .load_in(work_ld),
      .load_sel_in(load_sel), .bus_in(bus_q), .wdata_out(alu_wdata));

   task automatic final_report();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic timeout();
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen at a rising edge, as the bus demands.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) timeout();
   endtask

   // Kind bits are {write, read, mask}; the result is visible once the task returns.
   task automatic rf_op(input logic [2:0] k, input a_src_type as, input b_src_type bs, input logic [3:0] a,
      input logic [3:0] b, input logic [15:0] d);
      @(posedge clk);
      {rf_wr, rf_rd, mask_en} <= k;
      a_src <= as;
      b_src <= bs;
      ma <= a;
      mb <= b;
      wdata <= d;
      @(posedge clk);
      {rf_wr, rf_rd, mask_en} <= 3'h0;
      #1;
   endtask

   task automatic get(input logic [2:0] k, input a_src_type as, input b_src_type bs, input logic [3:0] a,
      input logic [3:0] b, input logic [15:0] exp);
      rf_op(k, as, bs, a, b, 16'h0000);
      chk({15'h0, bus_v, bus_q}, {16'h0001, exp});
   endtask

   initial begin
      int i;
      logic [31:0] r;
      logic e;
      a_src_type a_tab [5];
      logic [15:0] m_tab [5];
      b_src_type b_tab [3];
      logic [3:0] ix [3];
      a_tab = '{A_MICRO, A_SRCREG, A_BITLVL, A_LEVEL, A_LOOP};
      m_tab = '{16'h8000, 16'h0008, 16'h0800, 16'h0001, 16'h4000};
      b_tab = '{B_SRCREG, B_DSTREG, B_LOOP};
      ix = '{4'h3, 4'h6, 4'hE};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `OFF_STATUS, 32'h0, r, e);
      chk(r, 32'h0000_0800);
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      apb(1'b1, `OFF_MAPWR, 32'h0005_0123, r, e);
      @(posedge clk);
      instr <= 16'h015E;
      seq_src <= SEQ_MAP;
      @(posedge clk);
      seq_src <= SEQ_NEXT;
      #1;
      chk(32'(uaddr), 32'h0000_0123);
      chk(32'(opcode), 32'h0000_015E);
      @(posedge clk);
      done <= 1'b1;
      #1;
      chk(32'(uaddr), 32'h0000_0124);
      @(posedge clk);
      done <= 1'b0;
      irq <= 1'b1;
      seq_src <= SEQ_MAP;
      #1;
      chk(32'(uaddr), 32'h0000_0000);
      @(posedge clk);
      irq <= 1'b0;
      seq_src <= SEQ_NEXT;
      stack_op <= STK_PUSH;
      #1;
      chk(32'(uaddr), 32'h0000_0010);
      repeat (5) @(posedge clk);
      stack_op <= STK_HOLD;
      apb(1'b0, `OFF_SEQ, 32'h0, r, e);
      chk(32'(r[14:12]), 32'h0000_0004);
      @(posedge clk);
      seq_src <= SEQ_RETURN;
      stack_op <= STK_POP;
      @(posedge clk);
      seq_src <= SEQ_JUMP;
      stack_op <= STK_HOLD;
      branch <= 12'h2C5;
      #1;
      chk(32'(uaddr), 32'h0000_0014);
      @(posedge clk);
      seq_src <= SEQ_REPEAT;
      #1;
      chk(32'(uaddr), 32'h0000_02C5);
      @(posedge clk);
      seq_src <= SEQ_RETURN;
      stack_op <= STK_POP;
      #1;
      chk(32'(uaddr), 32'h0000_02C5);
      @(posedge clk);
      seq_src <= SEQ_NEXT;
      stack_op <= STK_LOAD;
      #1;
      chk(32'(uaddr), 32'h0000_0013);
      @(posedge clk);
      seq_src <= SEQ_RETURN;
      stack_op <= STK_POP;
      @(posedge clk);
      seq_src <= SEQ_NEXT;
      stack_op <= STK_HOLD;
      #1;
      chk(32'(uaddr), 32'h0000_0014);
      for (i = 0; i < 16; i++) begin
         rf_op(3'h4, A_MICRO, B_MICRO, 4'(i), 4'(15 - i), 16'h5A00 + 16'(i));
      end
      for (i = 0; i < 16; i++) begin
         get(3'h2, A_MICRO, B_MICRO, 4'(i), 4'(15 - i), 16'h5A00 + 16'(i));
      end
      @(posedge clk);
      loop_ld <= 1'b1;
      loop_opl <= 1'b1;
      @(posedge clk);
      loop_ld <= 1'b0;
      for (i = 0; i < 5; i++) begin
         get(3'h1, a_tab[i], B_MICRO, 4'hF, 4'h0, m_tab[i]);
      end
      for (i = 0; i < 3; i++) begin
         rf_op(3'h4, A_MICRO, b_tab[i], 4'h4, 4'h0, 16'hB000 + 16'(i));
         get(3'h2, A_MICRO, B_MICRO, 4'h4, ix[i], 16'hB000 + 16'(i));
      end
      @(posedge clk);
      loop_dec <= 1'b1;
      @(posedge clk);
      loop_dec <= 1'b0;
      get(3'h1, A_LOOP, B_MICRO, 4'h0, 4'h0, 16'h2000);
      @(posedge clk);
      flags_v <= 1'b1;
      carry <= 1'b1;
      ovf <= 1'b1;
      @(posedge clk);
      carry <= 1'b0;
      ovf <= 1'b0;
      #1;
      chk(32'(status_lo[3:1]), 32'h0000_0007);
      @(posedge clk);
      flags_v <= 1'b0;
      {err_evt, spill_v, spill, bit_wr, bit_d} <= 5'h1F;
      #1;
      chk(32'(status_lo[3:1]), 32'h0000_0002);
      @(posedge clk);
      {err_evt, spill_v, spill, bit_wr, bit_d} <= 5'h00;
      status_ld <= 1'b1;
      wdata <= 16'hFFA1;
      #1;
      chk({23'h0, err_irq, status_lo}, 32'h0000_0135);
      @(posedge clk);
      status_ld <= 1'b0;
      #1;
      chk({22'h0, err_irq, alt_tab, status_lo}, 32'h0000_01A1);
      apb(1'b0, `OFF_STATUS, 32'h0, r, e);
      chk(r, 32'h0000_08A1);
      rf_op(3'h4, A_MICRO, B_MICRO, 4'h2, 4'h0, 16'h0041);
      rf_op(3'h4, A_MICRO, B_MICRO, 4'h2, 4'h1, 16'h1234);
      @(posedge clk);
      lvl_chg <= 1'b1;
      new_lvl <= 4'h2;
      @(posedge clk);
      lvl_chg <= 1'b0;
      apb(1'b0, `OFF_LEVEL, 32'h0, r, e);
      chk(r, 32'h0000_0010);
      for (i = 0; i < 40 && cur_lvl !== 4'h2; i++) @(posedge clk);
      if (i == 40) timeout();
      repeat (2) @(posedge clk);
      #1;
      chk({16'h0, alu_u.work_q[1]}, 32'h0000_1234);
      chk(32'(status_lo), 32'h0000_0041);
      apb(1'b0, `OFF_STATUS, 32'h0, r, e);
      chk(r, 32'h0000_2841);
      get(3'h2, A_MICRO, B_MICRO, 4'h0, 4'h3, 16'h00A3);
      rf_op(3'h2, A_MICRO, B_MICRO, 4'h0, 4'h0, 16'h0000);
      chk(32'(bus_q[7:0]), 32'h0000_00A1);
      apb(1'b1, `OFF_STATUS, 32'h0000_0700, r, e);
      apb(1'b0, `OFF_LEVEL, 32'h0, r, e);
      chk(r, 32'h0000_0002);
      @(posedge clk);
      status_ld <= 1'b1;
      err_evt <= 1'b1;
      wdata <= 16'hFF02;
      @(posedge clk);
      status_ld <= 1'b0;
      err_evt <= 1'b0;
      apb(1'b0, `OFF_STATUS, 32'h0, r, e);
      chk(r, 32'h0000_2F12);
      final_report();
   end
endmodule
